// [byte_table_translate_unit.sv]
// Byte table translate unit: decode, execution engine and APB registers.
// Overview of operation
// - Table address is table base plus zero-extended target byte.
// - Incrementing forms write the table byte over the target byte.
// - Incrementing forms add one to the destination pointer per step.
// - Every step subtracts one from the 16-bit counter.
// - Repeating form loops until the counter reaches zero, 1 to 65536.
// - Replacing forms also load the table byte into the scratch high byte.
// - The table base pointer is never modified by these operations.
// - Repeating form takes interrupts between steps, saving start PC.
// - Each accepted interrupt adds seven cycles to execution time.
// - Repeat completion sets count end; nil flag left alone.
// - Single step sets count end when counter is zero, else clears.
// - Single step decodes b8, nonzero pointer, 0; costs 25 cycles.
// - Repeat form has low nibble 4; costs 11 plus 14 per byte.
// - Test form has low nibble a, nonzero scan and table fields.
// - Pointers are 16-bit or 32-bit pairs; counter is a word.
// - Test form loads scratch high byte, never writes the target.
// - Test form decrements pointer and counter, sets nil and end flags.
`timescale 1ns/1ps
`default_nettype none
`include "byte_xlat_regs.svh"
module byte_table_translate_unit
    import byte_xlat_pkg::*;
(
    // Clock and reset.
    input  wire logic        pclk,
    input  wire logic        presetn,
    // APB slave.
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output var  logic [31:0] prdata,
    output var  logic        pready,
    output var  logic        pslverr,
    // Byte memory bus.
    output var  mem_req_t    mem_req,
    output var  logic        mem_valid,
    input  wire logic        mem_ready,
    input  wire logic [7:0]  mem_rdata,
    input  wire logic        mem_rvalid,
    output var  logic        mem_rready,
    // Interrupt handshake with the sequencer.
    input  wire logic        irq_req,
    input  wire logic [15:0] instr_pc,
    output var  logic        irq_ack
);

    ////////////////////////////////////////////////////////////////////////
    // Decode of the two instruction words.
    function automatic op_t decode(input logic [31:0] w);
        op_t o;
        o = OP_NONE;
        if (w[15:8] == `OPC_HIGH && w[7:4] != 4'h0 &&
            w[31:28] == 4'h0 && w[23:20] != 4'h0 && w[19:16] == 4'h0) begin
            unique case (w[3:0])
                `NIB_INC:      o = OP_INC;
                `NIB_INC_REP:  o = OP_REP;
                `NIB_TEST_DEC: o = OP_TEST;
                default:       o = OP_NONE;
            endcase
        end
        return o;
    endfunction

    // Offset arithmetic: segmented pairs keep the segment word intact.
    function automatic logic [31:0] offs(input logic [31:0] p,
                                         input logic [15:0] d,
                                         input logic        seg);
        logic [15:0] lo;
        lo = p[15:0] + d;
        return seg ? {p[31:16], lo} : {16'h0000, lo};
    endfunction

    state_t      state;
    op_t         op;
    logic        seg;
    logic [31:0] instr;
    logic [31:0] dst_ptr;
    logic [31:0] src_ptr;
    logic [15:0] count;
    logic [7:0]  scratch_high_byte;
    logic [15:0] cycles;
    logic [15:0] saved_pc;
    logic        busy;
    logic        done;
    logic        illegal;
    logic        irq_taken;
    logic        count_end_flag;
    logic        result_nil_flag;
    logic [2:0]  irq_cnt;
    logic [7:0]  target;
    logic [7:0]  table_val;
    logic        apb_wr;
    logic        apb_rd;
    logic        start;
    logic [15:0] next_count;

    // Writes land at the completing edge, where pready is seen high.
    assign apb_wr     = psel && penable && pwrite && pready;
    assign apb_rd     = psel && penable && !pwrite && !pready;
    assign start      = apb_wr && paddr == `OFS_CTRL && pwdata[`CTRL_START]
                        && !busy;
    assign next_count = count - 16'h0001;

    ////////////////////////////////////////////////////////////////////////
    // Two-entry buffer on the read data path.
    logic [7:0] buf_mem [2];
    logic       buf_wp;
    logic       buf_rp;
    logic [1:0] buf_cnt;
    logic       buf_push;
    logic       buf_pop;
    logic       buf_valid;

    assign buf_valid = buf_cnt != 2'h0;
    assign buf_push  = mem_rvalid && mem_rready;
    // The engine only drains while waiting for a read, so a slow engine
    // backs up into the memory through mem_rready.
    assign buf_pop   = buf_valid && (state == S_WT_TGT || state == S_WT_TBL);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            buf_wp     <= 1'b0;
            buf_rp     <= 1'b0;
            buf_cnt    <= 2'h0;
            mem_rready <= 1'b1;
        end else begin
            if (buf_push) begin
                buf_mem[buf_wp] <= mem_rdata;
                buf_wp          <= ~buf_wp;
            end
            if (buf_pop) begin
                buf_rp <= ~buf_rp;
            end
            buf_cnt    <= buf_cnt + {1'b0, buf_push} - {1'b0, buf_pop};
            mem_rready <= (buf_cnt + {1'b0, buf_push} - {1'b0, buf_pop})
                          != 2'h2;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Execution engine.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state     <= S_IDLE;
            op        <= OP_NONE;
            mem_valid <= 1'b0;
            mem_req   <= '0;
            target    <= 8'h00;
            table_val <= 8'h00;
            irq_cnt   <= 3'h0;
            irq_ack   <= 1'b0;
        end else begin
            irq_ack <= 1'b0;
            unique case (state)
                S_IDLE: begin
                    if (start && decode(instr) != OP_NONE) begin
                        op    <= decode(instr);
                        state <= S_RD_TGT;
                    end
                end
                S_RD_TGT: begin
                    mem_req   <= '{addr: dst_ptr, wdata: 8'h00, we: 1'b0};
                    mem_valid <= 1'b1;
                    state     <= S_WT_TGT;
                end
                S_WT_TGT: begin
                    if (mem_valid && mem_ready) begin
                        mem_valid <= 1'b0;
                    end
                    if (buf_pop) begin
                        target <= buf_mem[buf_rp];
                        state  <= S_RD_TBL;
                    end
                end
                S_RD_TBL: begin
                    mem_req   <= '{addr: offs(src_ptr, {8'h00, target}, seg),
                                   wdata: 8'h00, we: 1'b0};
                    mem_valid <= 1'b1;
                    state     <= S_WT_TBL;
                end
                S_WT_TBL: begin
                    if (mem_valid && mem_ready) begin
                        mem_valid <= 1'b0;
                    end
                    if (buf_pop) begin
                        table_val <= buf_mem[buf_rp];
                        state     <= (op == OP_TEST) ? S_UPD : S_WR_TGT;
                    end
                end
                S_WR_TGT: begin
                    if (!mem_valid) begin
                        mem_req   <= '{addr: dst_ptr, wdata: table_val,
                                       we: 1'b1};
                        mem_valid <= 1'b1;
                    end else if (mem_ready) begin
                        mem_valid <= 1'b0;
                        state     <= S_UPD;
                    end
                end
                S_UPD: begin
                    if (op == OP_REP && next_count != 16'h0000) begin
                        state <= irq_req ? S_IRQ : S_RD_TGT;
                    end else begin
                        state <= S_IDLE;
                    end
                    irq_cnt <= 3'h0;
                end
                S_IRQ: begin
                    irq_cnt <= irq_cnt + 3'h1;
                    if (irq_cnt == `IRQ_WAIT_LAST) begin
                        irq_ack <= 1'b1;
                        state   <= S_IDLE;
                    end
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Pointer, counter and scratch updates; software loads the pointers and counter when idle.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dst_ptr           <= `RST_WORD;
            src_ptr           <= `RST_WORD;
            count             <= 16'h0000;
            scratch_high_byte <= 8'h00;
        end else if (state == S_UPD) begin
            dst_ptr <= offs(dst_ptr, (op == OP_TEST) ? 16'hffff : 16'h0001,
                            seg);
            count   <= next_count;
            scratch_high_byte <= table_val;
        end else if (apb_wr && !busy) begin
            // table base written only by software
            if (paddr == `OFS_DST_PTR) dst_ptr <= pwdata;
            if (paddr == `OFS_SRC_PTR) src_ptr <= pwdata;
            if (paddr == `OFS_COUNT)   count   <= pwdata[15:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Control, flags, cycle cost and saved program counter.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            seg             <= 1'b0;
            instr           <= `RST_WORD;
            busy            <= 1'b0;
            done            <= 1'b0;
            illegal         <= 1'b0;
            irq_taken       <= 1'b0;
            count_end_flag  <= 1'b0;
            result_nil_flag <= 1'b0;
            cycles          <= 16'h0000;
            saved_pc        <= 16'h0000;
        end else begin
            if (apb_wr && !busy && paddr == `OFS_INSTR) instr <= pwdata;
            if (apb_wr && !busy && paddr == `OFS_CTRL) begin
                // pointer width follows the mode bit
                seg <= pwdata[`CTRL_SEG];
            end
            if (start) begin
                illegal   <= decode(instr) == OP_NONE;
                busy      <= decode(instr) != OP_NONE;
                done      <= decode(instr) == OP_NONE;
                irq_taken <= 1'b0;
                cycles    <= (decode(instr) == OP_REP) ? `CYC_REP_BASE :
                             `CYC_SINGLE;
            end
            if (state == S_UPD) begin
                if (op == OP_REP) begin
                    cycles <= cycles + `CYC_REP_STEP;
                end
                count_end_flag <= next_count == 16'h0000;
                if (op == OP_TEST) begin
                    result_nil_flag <= table_val == 8'h00;
                end
                if (!(op == OP_REP && next_count != 16'h0000)) begin
                    busy <= 1'b0;
                    done <= 1'b1;
                end
                if (op == OP_REP && next_count != 16'h0000 && irq_req) begin
                    saved_pc <= instr_pc;
                end
            end
            if (state == S_IRQ && irq_cnt == `IRQ_WAIT_LAST) begin
                busy      <= 1'b0;
                irq_taken <= 1'b1;
                cycles    <= cycles + `CYC_IRQ;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // APB slave: one wait state, then a registered answer.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= `RST_WORD;
        end else begin
            pready  <= psel && penable && !pready;
            pslverr <= psel && penable && !pready && paddr > `OFS_SAVED_PC;
            prdata  <= `RST_WORD;
            if (apb_rd) begin
                unique case (paddr)
                    `OFS_CTRL:     prdata <= {30'h0, seg, 1'b0};
                    `OFS_INSTR:    prdata <= instr;
                    `OFS_DST_PTR:  prdata <= dst_ptr;
                    `OFS_SRC_PTR:  prdata <= src_ptr;
                    `OFS_COUNT:    prdata <= {16'h0000, count};
                    `OFS_STATUS:   prdata <= {26'h0, result_nil_flag,
                                              count_end_flag, irq_taken,
                                              illegal, done, busy};
                    `OFS_SCRATCH:  prdata <= {24'h0, scratch_high_byte};
                    `OFS_CYCLES:   prdata <= {16'h0000, cycles};
                    `OFS_SAVED_PC: prdata <= {16'h0000, saved_pc};
                    default:       prdata <= `RST_WORD;
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks.
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    property p_tbl_addr;
        state == S_RD_TBL |=> mem_req.addr[15:0] ==
            $past(src_ptr[15:0]) + {8'h00, $past(target)};
    endproperty
    a_tbl_addr: assert property (p_tbl_addr)
        else $error("table address not base plus index");

    property p_no_test_write;
        op == OP_TEST && busy |-> !(mem_valid && mem_req.we);
    endproperty
    a_no_test_write: assert property (p_no_test_write)
        else $error("test form wrote memory");

    property p_wr_data;
        state == S_WR_TGT && mem_valid |-> mem_req.wdata == table_val;
    endproperty
    a_wr_data: assert property (p_wr_data)
        else $error("target write data is not the table byte");

    property p_ptr_step;
        state == S_UPD && op != OP_TEST |=>
            dst_ptr[15:0] == $past(dst_ptr[15:0]) + 16'h0001;
    endproperty
    a_ptr_step: assert property (p_ptr_step)
        else $error("destination pointer not incremented");

    property p_cnt_step;
        state == S_UPD |=> count == $past(count) - 16'h0001;
    endproperty
    a_cnt_step: assert property (p_cnt_step)
        else $error("counter not decremented");

    property p_src_fixed;
        busy |=> $stable(src_ptr);
    endproperty
    a_src_fixed: assert property (p_src_fixed)
        else $error("table base changed during execution");

    property p_rep_loop;
        state == S_UPD && op == OP_REP && next_count != 16'h0000 && !irq_req
            |=> state == S_RD_TGT ##1 state == S_WT_TGT;
    endproperty
    a_rep_loop: assert property (p_rep_loop)
        else $error("repeat did not continue");

    property p_irq_len;
        state == S_UPD && op == OP_REP && next_count != 16'h0000 && irq_req
            |=> (state == S_IRQ && !irq_ack) [*7] ##1 irq_ack && !busy;
    endproperty
    a_irq_len: assert property (p_irq_len)
        else $error("interrupt entry not seven cycles");

    property p_end_flag;
        state == S_UPD |=> count_end_flag == (count == 16'h0000);
    endproperty
    a_end_flag: assert property (p_end_flag)
        else $error("count end flag wrong");

    property p_nil_flag;
        state == S_UPD && op == OP_TEST |=>
            result_nil_flag == (scratch_high_byte == 8'h00);
    endproperty
    a_nil_flag: assert property (p_nil_flag)
        else $error("result nil flag wrong");

endmodule
`default_nettype wire

// [byte_xlat_regs.svh]
// Register offsets, field positions, reset values and timing counts.
`ifndef BYTE_XLAT_REGS_SVH
`define BYTE_XLAT_REGS_SVH
`define OFS_CTRL       8'h00
`define OFS_INSTR      8'h04
`define OFS_DST_PTR    8'h08
`define OFS_SRC_PTR    8'h0c
`define OFS_COUNT      8'h10
`define OFS_STATUS     8'h14
`define OFS_SCRATCH    8'h18
`define OFS_CYCLES     8'h1c
`define OFS_SAVED_PC   8'h20
`define CTRL_START     0
`define CTRL_SEG       1
`define ST_BUSY        0
`define ST_DONE        1
`define ST_ILLEGAL     2
`define ST_IRQ         3
`define ST_COUNT_END   4
`define ST_RESULT_NIL  5
`define OPC_HIGH       8'hb8
`define NIB_INC        4'h0
`define NIB_INC_REP    4'h4
`define NIB_TEST_DEC   4'ha
`define CYC_SINGLE     16'h0019
`define CYC_REP_BASE   16'h000b
`define CYC_REP_STEP   16'h000e
`define CYC_IRQ        16'h0007
`define IRQ_WAIT_LAST  3'h6
`define RST_WORD       32'h0000_0000
`endif

// [byte_xlat_pkg.sv]
// Types shared by the byte translate unit.
package byte_xlat_pkg;
    typedef struct packed {
        logic [31:0] addr;
        logic [7:0]  wdata;
        logic        we;
    } mem_req_t;
    typedef enum logic [1:0] {
        OP_NONE = 2'h0,
        OP_INC  = 2'h1,
        OP_REP  = 2'h2,
        OP_TEST = 2'h3
    } op_t;
    typedef enum logic [7:0] {
        S_IDLE   = 8'h01,
        S_RD_TGT = 8'h02,
        S_WT_TGT = 8'h04,
        S_RD_TBL = 8'h08,
        S_WT_TBL = 8'h10,
        S_WR_TGT = 8'h20,
        S_UPD    = 8'h40,
        S_IRQ    = 8'h80
    } state_t;
endpackage

// [byte_mem_model.sv]
// Byte-wide memory model that answers the translate unit's memory bus.
`timescale 1ns/1ps
`default_nettype none
module byte_mem_model
    import byte_xlat_pkg::*;
(
    // Clock and reset.
    input  wire logic        pclk,
    input  wire logic        presetn,
    // Request side.
    input  wire mem_req_t    mem_req,
    input  wire logic        mem_valid,
    output var  logic        mem_ready,
    // Read return.
    output var  logic [7:0]  mem_rdata,
    output var  logic        mem_rvalid,
    input  wire logic        mem_rready,
    // Wait states inserted before each accept.
    input  wire logic [3:0]  slow
);
    logic [7:0]  bytes [0:65535];
    logic [3:0]  waited;
    logic [15:0] seg_seen;
    int          reads;
    int          writes;

    ////////////////////////////////////////////////////////////////////////
    // One request at a time; a return held by a stall keeps its byte, and
    // a popped return line shows garbage so a late sample cannot pass.
    // single byte accesses
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mem_ready  <= 1'b0;
            mem_rvalid <= 1'b0;
            mem_rdata  <= 8'h5a;
            waited     <= 4'h0;
            seg_seen   <= 16'h0000;
            reads      <= 0;
            writes     <= 0;
        end else begin
            if (mem_rvalid && mem_rready) begin
                mem_rvalid <= 1'b0;
                mem_rdata  <= ~mem_rdata;
            end
            if (mem_valid && mem_ready) begin
                mem_ready <= 1'b0;
                waited    <= 4'h0;
                seg_seen  <= mem_req.addr[31:16];
                if (mem_req.we) begin
                    bytes[mem_req.addr[15:0]] <= mem_req.wdata;
                    writes <= writes + 1;
                end else begin
                    mem_rdata  <= bytes[mem_req.addr[15:0]];
                    mem_rvalid <= 1'b1;
                    reads      <= reads + 1;
                end
            end else if (mem_valid && waited >= slow) begin
                mem_ready <= 1'b1;
            end else if (mem_valid) begin
                waited <= waited + 4'h1;
            end
        end
    end
endmodule
`default_nettype wire

// [test_byte_table_translate_unit.sv]
// Self-checking testbench for the byte table translate unit.
`timescale 1ns/1ps
`default_nettype none
`include "byte_xlat_regs.svh"
module test_byte_table_translate_unit
    import byte_xlat_pkg::*;
;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [7:0]  paddr, mem_rdata;
    logic [31:0] pwdata, prdata, q, st;
    mem_req_t    mem_req;
    logic        mem_valid, mem_ready, mem_rvalid, mem_rready;
    logic        irq_req, irq_ack, err;
    logic [15:0] instr_pc;
    logic [3:0]  slow;
    int          bad_count, comparisons, acks, r0, w0;

    byte_table_translate_unit dut (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .mem_req(mem_req), .mem_valid(mem_valid),
        .mem_ready(mem_ready), .mem_rdata(mem_rdata),
        .mem_rvalid(mem_rvalid), .mem_rready(mem_rready),
        .irq_req(irq_req), .instr_pc(instr_pc), .irq_ack(irq_ack));
    byte_mem_model mem (.pclk(pclk), .presetn(presetn), .mem_req(mem_req),
        .mem_valid(mem_valid), .mem_ready(mem_ready),
        .mem_rdata(mem_rdata), .mem_rvalid(mem_rvalid),
        .mem_rready(mem_rready), .slow(slow));

    ////////////////////////////////////////////////////////////////////////
    // Free-running clock and acknowledge pulse counter.
    always #5 pclk = ~pclk;
    always @(posedge pclk) begin
        if (irq_ack === 1'b1) acks++;
    end

    // One APB transfer; request held until pready is sampled high.
    task automatic apb(input logic wr, input logic [7:0] a,
                       input logic [31:0] d, output logic [31:0] rd);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1) bad_count++;
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            bad_count++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] rd;
        apb(1'b0, a, 32'h0, rd);
        chk(rd, exp);
    endtask

    function automatic logic [31:0] mk(input logic [3:0] nib, p);
        // Counter field 12 and table field 9 stay apart from the pointer.
        return {4'h0, 4'hc, 4'h9, 4'h0, `OPC_HIGH, p, nib};
    endfunction

    // Loads the operands, starts, and polls until the unit is idle.
    task automatic run(input logic [31:0] ins, dst, src,
                       input logic [15:0] cnt, input logic seg);
        int n;
        n = 0;
        r0 = mem.reads;
        w0 = mem.writes;
        apb(1'b1, `OFS_INSTR, ins, q);
        apb(1'b1, `OFS_DST_PTR, dst, q);
        apb(1'b1, `OFS_SRC_PTR, src, q);
        apb(1'b1, `OFS_COUNT, {16'h0, cnt}, q);
        apb(1'b1, `OFS_CTRL, {30'h0, seg, 1'b1}, q);
        do begin
            apb(1'b0, `OFS_STATUS, 32'h0, st);
            n++;
        end while (st[`ST_BUSY] !== 1'b0 && n < 3000);
        if (st[`ST_BUSY] !== 1'b0) bad_count++;
    endtask

    task automatic tally_and_finish;
        $display("comparisons=%0d mismatches=%0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // Watchdog: far longer than the whole sequence needs.
    initial begin
        #400000;
        bad_count++;
        tally_and_finish;
    end

    ////////////////////////////////////////////////////////////////////////
    // Main sequence.
    initial begin
        {pclk, presetn, psel, penable, pwrite, irq_req} = 6'h00;
        {paddr, pwdata, slow, bad_count, comparisons, acks} = '0;
        instr_pc = 16'h1234;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        rdchk(`OFS_STATUS, 32'h0);
        apb(1'b0, 8'h24, 32'h0, q);
        chk({q[31:1], q[0] ^ err}, 32'h1);
        // Single step, then a 0xff target at the last count.
        mem.bytes[16'h4001] = 8'h03;
        mem.bytes[16'h1003] = 8'haa;
        run(mk(`NIB_INC, 4'h6), 32'h4001, 32'h1000, 16'h2, 1'b0);
        chk(mem.bytes[16'h4001], 32'haa);
        rdchk(`OFS_DST_PTR, 32'h4002);
        rdchk(`OFS_COUNT, 32'h1);
        rdchk(`OFS_SRC_PTR, 32'h1000);
        chk(st[`ST_COUNT_END], 32'h0);
        rdchk(`OFS_CYCLES, 32'h19);
        chk(mem.reads - r0 + 4 * (mem.writes - w0), 32'h6);
        mem.bytes[16'h4002] = 8'hff;
        mem.bytes[16'h10ff] = 8'h5c;
        mem.bytes[16'h0fff] = 8'h11;
        run(mk(`NIB_INC, 4'h6), 32'h4002, 32'h1000, 16'h1, 1'b0);
        chk(mem.bytes[16'h4002], 32'h5c);
        chk(st[`ST_COUNT_END], 32'h1);
        // Repeat over three bytes against a slow memory.
        slow <= 4'h2;
        {mem.bytes[16'h4000], mem.bytes[16'h4001]} = 16'h0040;
        mem.bytes[16'h4002] = 8'h80;
        {mem.bytes[16'h2040], mem.bytes[16'h2080]} = 16'h4000;
        mem.bytes[16'h2000] = 8'h00;
        run(mk(`NIB_INC_REP, 4'h6), 32'h4000, 32'h2000, 16'h3, 1'b0);
        chk({mem.bytes[16'h4001], mem.bytes[16'h4002]}, 32'h4000);
        rdchk(`OFS_DST_PTR, 32'h4003);
        rdchk(`OFS_COUNT, 32'h0);
        chk(st[`ST_COUNT_END], 32'h1);
        rdchk(`OFS_CYCLES, 32'h35);
        chk(mem.reads - r0 + 16 * (mem.writes - w0), 32'h36);
        // Test form: no write, pointer goes down, flags from value/count.
        slow <= 4'h0;
        mem.bytes[16'h4001] = 8'h03;
        run(mk(`NIB_TEST_DEC, 4'h6), 32'h4001, 32'h1000, 16'h2, 1'b0);
        rdchk(`OFS_SCRATCH, 32'haa);
        chk(mem.bytes[16'h4001] + 256 * (mem.writes - w0), 32'h3);
        rdchk(`OFS_DST_PTR, 32'h4000);
        rdchk(`OFS_COUNT, 32'h1);
        chk(st[`ST_RESULT_NIL:`ST_COUNT_END], 32'h0);
        mem.bytes[16'h4000] = 8'h01;
        mem.bytes[16'h1001] = 8'h00;
        run(mk(`NIB_TEST_DEC, 4'h6), 32'h4000, 32'h1000, 16'h1, 1'b0);
        chk(st[`ST_RESULT_NIL:`ST_COUNT_END], 32'h3);
        rdchk(`OFS_SRC_PTR, 32'h1000);
        // Interrupt after the first step, then resume from saved state.
        for (int i = 0; i < 4; i++) begin
            mem.bytes[16'h5000 + i] = 8'(i + 1);
            mem.bytes[16'h3001 + i] = 8'(i + 8'h11);
        end
        irq_req <= 1'b1;
        run(mk(`NIB_INC_REP, 4'h6), 32'h5000, 32'h3000, 16'h4, 1'b0);
        chk({st[`ST_IRQ], st[`ST_DONE], st[`ST_BUSY]}, 32'h4);
        rdchk(`OFS_SAVED_PC, 32'h1234);
        rdchk(`OFS_COUNT, 32'h3);
        rdchk(`OFS_CYCLES, 32'h20);
        chk(acks, 32'h1);
        irq_req <= 1'b0;
        run(mk(`NIB_INC_REP, 4'h6), 32'h5001, 32'h3000, 16'h3, 1'b0);
        chk({mem.bytes[16'h5000], mem.bytes[16'h5003]}, 32'h1114);
        rdchk(`OFS_DST_PTR, 32'h5004);
        // Segmented pointers keep the upper word on the bus.
        mem.bytes[16'h4010] = 8'h05;
        mem.bytes[16'h1005] = 8'h77;
        run(mk(`NIB_INC, 4'h6), 32'h0003_4010, 32'h0003_1000, 16'h1, 1'b1);
        chk({mem.seg_seen, 8'h0, mem.bytes[16'h4010]}, 32'h0003_0077);
        rdchk(`OFS_DST_PTR, 32'h0003_4011);
        // A zero pointer field is not a legal encoding.
        run(mk(`NIB_INC, 4'h0), 32'h4000, 32'h1000, 16'h1, 1'b0);
        chk(st[`ST_ILLEGAL] + mem.reads - r0 + mem.writes - w0, 32'h1);
        chk({st[`ST_DONE], st[`ST_ILLEGAL]}, 32'h3);
        tally_and_finish;
    end
endmodule
`default_nettype wire
